// ---- testbench.sv ----
// testbench: drives the register bank, models the pins and judges results
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clock = 1'h0;
   logic            rstn = 1'h0;
   logic [7:0]      addr = 8'h00, wdata = 8'h00, rxb = 8'h00, txsb = 8'h00, dtd = 8'h00;
   logic            wr = 1'h0, rd = 1'h0, rxv = 1'h0, txs = 1'h0, ccf = 1'h0, tbe = 1'h0;
   logic            ltx = 1'h0, dbg = 1'h0, dtw = 1'h0, drr = 1'h0;
   logic            ext_tx = 1'h0, ext_lp = 1'h0, other = 1'h0;
   wire logic [7:0] rdata, tbb;
   wire logic       lrx, tbl, crc, halt, lowp, cal, tick, txq, rxq, irq, rx_drv;
   wire logic       tx_o, tx_oe, rx_o, rx_oe, lp_o, lp_oe;
   wire logic       tx_lvl = tx_oe ? tx_o : ext_tx;
   wire logic       rx_lvl = rx_oe ? rx_o : rx_drv;
   wire logic       lp_lvl = lp_oe ? lp_o : ext_lp;
   int              failures = 0, n_tests = 0, cycles = 0;
   logic [7:0]      regs [11] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
                                  8'h34, 8'h38, 8'h3C, 8'h40};
   logic [7:0]      fld [5] = '{8'h09, 8'h19, 8'h1F, 8'h10, 8'h08};
   logic [7:0]      eff [5] = '{8'h09, 8'h19, 8'h19, 8'h10, 8'h19};

   vbc_regs dut (.CLOCK(clock), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .RX_BYTE_VALID(rxv), .RX_BYTE(rxb), .TX_BYTE_SENT(txs),
      .TX_SENT_BYTE(txsb), .CC_FLAG_SET(ccf), .TX_BUF_EMPTY(tbe), .LINK_TX_ACTIVE(ltx),
      .DEBUG_MODE(dbg), .LINK_RX_ACTIVE(lrx), .TX_BUFFER_BYTE(tbb), .TX_BUFFER_LOAD(tbl),
      .CRC_APPEND(crc), .LINK_HALT(halt), .LOW_POWER(lowp), .CAL_ACTIVE(cal),
      .US_TICK(tick), .DMA_TX_WRITE(dtw), .DMA_TX_DATA(dtd), .DMA_RX_READ(drr),
      .TX_DMA_REQ(txq), .RX_DMA_REQ(rxq), .RX_IRQ(irq), .TX_PIN_I(tx_lvl), .TX_PIN_O(tx_o),
      .TX_PIN_OE(tx_oe), .RX_PIN_I(rx_lvl), .RX_PIN_O(rx_o), .RX_PIN_OE(rx_oe),
      .LP_PIN_I(lp_lvl), .LP_PIN_O(lp_o), .LP_PIN_OE(lp_oe));
   vbc_xcvr xcvr (.tx_lvl(tx_lvl), .lp_n_lvl(lp_lvl), .bus_other(other), .rx_drv(rx_drv));

   // ************************************************************
   // clock, timeout and shared tasks
   // ************************************************************
   always #5 clock = ~clock;
   // cuts a hang short
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(string n, logic e, logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      wr <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'h0;
      @(posedge clock);
   endtask
   task automatic rdc(logic [7:0] a, logic [7:0] e);
      rd <= 1'h1;
      addr <= a;
      @(posedge clock);
      rd <= 1'h0;
      @(posedge clock);
      chk($sformatf("reg %h", a), e, rdata);
   endtask
   // bits are tx, rx, loopback; levels compared only where driven
   task automatic pins(logic [2:0] oe, logic [2:0] o);
      cyc(2);
      chk("pin oe", {5'h00, oe}, {5'h00, tx_oe, rx_oe, lp_oe});
      chk("pin out", {5'h00, o}, {5'h00, {tx_o, rx_o, lp_o} & oe});
   endtask
   task automatic txw(logic [7:0] d, logic c);
      wr_reg(vbc_pkg::OFF_TXBUF, d);
      chk1("tx load", 1'h1, tbl);
      chk("tx byte", d, tbb);
      chk1("crc append", c, crc);
   endtask
   task automatic tick_gap(logic [7:0] e);
      int n;
      n = 0;
      repeat (2)
      begin
         while (tick !== 1'h1) @(posedge clock);
         @(posedge clock);
      end
      n = 1;
      while (tick !== 1'h1)
      begin
         @(posedge clock);
         n++;
      end
      chk("tick gap", e, n[7:0]);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      foreach (regs[i]) rdc(regs[i], 8'h00);
      wr_reg(vbc_pkg::OFF_CTRL, 8'hFF);
      rdc(vbc_pkg::OFF_CTRL, 8'h6F);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h00);
      wr_reg(vbc_pkg::OFF_PLEVEL, 8'hFF);
      rdc(vbc_pkg::OFF_PLEVEL, 8'h00);
      wr_reg(vbc_pkg::OFF_POUT, 8'hFF);
      rdc(vbc_pkg::OFF_POUT, 8'h07);
   endtask
   task automatic t_time();
      int n;
      int k;
      foreach (fld[i])
      begin
         wr_reg(vbc_pkg::OFF_CLKSET, fld[i]);
         tick_gap(eff[i]);
      end
      wr_reg(vbc_pkg::OFF_CLKSET, 8'h09);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h40);
      n = 0;
      while (cal === 1'h1 && n < 400)
      begin
         @(posedge clock);
         n++;
      end
      chk1("cal time", 1'h1, n > 9 * (vbc_pkg::CAL_TIME_US - 1) &&
           n <= 9 * vbc_pkg::CAL_TIME_US);
      rdc(vbc_pkg::OFF_CTRL, 8'h00);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h01);
      cyc(1);
      chk1("low power", 1'h1, lowp);
      k = 0;
      repeat (60)
      begin
         @(posedge clock);
         k += (tick === 1'h1);
      end
      chk("ticks in low power", 8'h00, k[7:0]);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h00);
      cyc(1);
      chk1("low power", 1'h0, lowp);
   endtask
   task automatic t_pins();
      ltx <= 1'h1;
      wr_reg(vbc_pkg::OFF_PFUNC, 8'h3F);
      pins(3'h5, 3'h1);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h20);
      pins(3'h5, 3'h0);
      wr_reg(vbc_pkg::OFF_PFUNC, 8'hFF);
      pins(3'h5, 3'h4);
      chk1("rx active", 1'h1, lrx);
      rdc(vbc_pkg::OFF_PLEVEL, 8'h06);
      wr_reg(vbc_pkg::OFF_PFUNC, 8'hBF);
      cyc(2);
      chk1("rx active", 1'h0, lrx);
      wr_reg(vbc_pkg::OFF_PFUNC, 8'h07);
      wr_reg(vbc_pkg::OFF_POUT, 8'h05);
      pins(3'h7, 3'h5);
      rdc(vbc_pkg::OFF_PLEVEL, 8'h05);
      wr_reg(vbc_pkg::OFF_PFUNC, 8'h00);
      ext_tx <= 1'h1;
      ext_lp <= 1'h1;
      pins(3'h0, 3'h0);
      rdc(vbc_pkg::OFF_PLEVEL, 8'h07);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h00);
      ltx <= 1'h0;
   endtask
   task automatic t_tx();
      wr_reg(vbc_pkg::OFF_TBC, 8'h01);
      txw(8'h3C, 1'h0);
      rdc(vbc_pkg::OFF_TBC, 8'h00);
      txw(8'hC3, 1'h1);
      wr_reg(vbc_pkg::OFF_AUX, 8'h02);
      txw(8'h99, 1'h0);
      wr_reg(vbc_pkg::OFF_TBC, 8'hFF);
      dtw <= 1'h1;
      dtd <= 8'h77;
      @(posedge clock);
      dtw <= 1'h0;
      @(posedge clock);
      chk("dma tx byte", 8'h77, tbb);
      rdc(vbc_pkg::OFF_TBC, 8'hFE);
      tbe <= 1'h1;
      cyc(2);
      chk1("tx dma req", 1'h0, txq);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h08);
      cyc(1);
      chk1("tx dma req", 1'h1, txq);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h00);
      cyc(1);
      chk1("tx dma req", 1'h0, txq);
   endtask
   task automatic t_rx();
      wr_reg(vbc_pkg::OFF_AUX, 8'h01);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h04);
      rxb <= 8'h5A;
      rxv <= 1'h1;
      @(posedge clock);
      rxv <= 1'h0;
      rdc(vbc_pkg::OFF_MIRROR, 8'h5A);
      chk1("rx irq", 1'h1, irq);
      chk1("rx dma req", 1'h1, rxq);
      rdc(vbc_pkg::OFF_AUX, 8'h81);
      rdc(vbc_pkg::OFF_RXBUF, 8'h5A);
      cyc(1);
      chk1("rx irq", 1'h0, irq);
      txsb <= 8'hA5;
      txs <= 1'h1;
      @(posedge clock);
      txs <= 1'h0;
      cyc(2);
      chk1("rx irq", 1'h1, irq);
      rdc(vbc_pkg::OFF_RXBUF, 8'hA5);
      ccf <= 1'h1;
      @(posedge clock);
      ccf <= 1'h0;
      cyc(1);
      rdc(vbc_pkg::OFF_CTRL, 8'h00);
      rxv <= 1'h1;
      @(posedge clock);
      rxv <= 1'h0;
      drr <= 1'h1;
      @(posedge clock);
      drr <= 1'h0;
      cyc(1);
      rdc(vbc_pkg::OFF_AUX, 8'h01);
   endtask
   task automatic t_susp();
      wr_reg(vbc_pkg::OFF_CTRL, 8'h02);
      dbg <= 1'h1;
      cyc(2);
      chk1("link halt", 1'h1, halt);
      wr_reg(vbc_pkg::OFF_CTRL, 8'h00);
      cyc(1);
      chk1("link halt", 1'h0, halt);
      dbg <= 1'h0;
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(posedge clock);
      rstn <= 1'h1;
      repeat (3) @(posedge clock);
      t_reset();
      t_time();
      t_pins();
      t_tx();
      t_rx();
      t_susp();
      results();
   end
endmodule
`default_nettype wire

// ---- vbc_pkg.sv ----
// package: register map, field positions, reset values and timing of the pin/control bank
`default_nettype none
package vbc_pkg;

   // ***********************************************************
   // register byte addresses
   // ***********************************************************
   localparam logic [7:0] OFF_CTRL   = 8'h18;
   localparam logic [7:0] OFF_CLKSET = 8'h1C;
   localparam logic [7:0] OFF_TBC    = 8'h20;
   localparam logic [7:0] OFF_PFUNC  = 8'h24;
   localparam logic [7:0] OFF_POUT   = 8'h28;
   localparam logic [7:0] OFF_PLEVEL = 8'h2C;
   localparam logic [7:0] OFF_MIRROR = 8'h30;
   localparam logic [7:0] OFF_RXBUF  = 8'h34;
   localparam logic [7:0] OFF_TXBUF  = 8'h38;
   localparam logic [7:0] OFF_AUX    = 8'h3C;

   // ***********************************************************
   // peripheral_control bits
   // ***********************************************************
   localparam int BIT_CAL    = 6;
   localparam int BIT_LOOP   = 5;
   localparam int BIT_TXDMA  = 3;
   localparam int BIT_RXDMA  = 2;
   localparam int BIT_SUSP   = 1;
   localparam int BIT_LOWP   = 0;
   localparam logic [7:0] CTRL_WMASK = 8'h6F;

   // ***********************************************************
   // pin_function_control bits, pin index order tx, rx, loopback
   // ***********************************************************
   localparam int BIT_TX_POL = 7;
   localparam int BIT_RX_POL = 6;
   localparam int BIT_FUN_LO = 3;
   localparam int BIT_DIR_LO = 0;
   localparam int PIN_TX     = 2;
   localparam int PIN_RX     = 1;
   localparam int PIN_LP     = 0;
   localparam int NUM_PINS   = 3;

   // ***********************************************************
   // aux register bits
   // ***********************************************************
   localparam int BIT_IRQ_EN = 0;
   localparam int BIT_NO_CRC = 1;
   localparam int BIT_RBF    = 7;

   // ***********************************************************
   // reset values and timing
   // ***********************************************************
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [4:0] RST_CLK   = 5'h00;
   localparam logic [4:0] MHZ_MIN   = 5'h09;
   localparam logic [4:0] MHZ_MAX   = 5'h19;
   localparam logic [4:0] MHZ_DFLT  = 5'h19;
   localparam int         CAL_TIME_US = 10;
   localparam int         CAL_W     = $clog2(CAL_TIME_US + 1);
   localparam logic [CAL_W-1:0] CAL_CYCLES_US = CAL_W'(CAL_TIME_US);

endpackage
`default_nettype wire

// ---- vbc_regs.sv ----
// vbc_regs: control, pin and buffer register bank of the vehicle serial controller
// What this block does
// - calibrate_enable starts calibration and clears itself when calibration completes.
// - loopback_enable drives loopback_n_pin low in link mode.
// - DMA requests only while their enable bits are set.
// - debug_suspend_enable halts link one cycle after CPU enters debug, while it stays in debug.
// - low_power_request powers down and stops internal timing.
// - illegal interface_clock_mhz values time as 25 MHz.
// - tx_bytes_remaining decrements on each tx_data_buffer write by CPU or DMA, holding at zero.
// - write past zero appends CRC unless crc_append_disable is set.
// - at most 256 data bytes per message, count held in eight bits.
// - tx_polarity chooses active level driven on the transmit pin.
// - rx_polarity chooses which receive pin level counts as active.
// - function bits hand each pin to GPIO or the link.
// - direction bits apply only while a pin is GPIO.
// - data-out bits drive a pin only when GPIO and output.
// - pin level register shows all three pin levels in any mode.
// - mirror returns the receive byte without clearing the full flag.
// - completed received byte loads buffer and sets full flag.
// - each transmitted byte loops back into buffer and sets full flag, unless a received byte completes in the same cycle.
// - CPU buffer read clears full flag; interrupt while flag and enable.
// - completion code event clears the receive DMA enable.
//
// Added by the designer: the strobed register port.
`default_nettype none
module vbc_regs
(
   input  wire logic       CLOCK,
   input  wire logic       RSTN,
   // register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output var  logic [7:0] RDATA,
   // link engine side
   input  wire logic       RX_BYTE_VALID,
   input  wire logic [7:0] RX_BYTE,
   input  wire logic       TX_BYTE_SENT,
   input  wire logic [7:0] TX_SENT_BYTE,
   input  wire logic       CC_FLAG_SET,
   input  wire logic       TX_BUF_EMPTY,
   input  wire logic       LINK_TX_ACTIVE,
   input  wire logic       DEBUG_MODE,
   output var  logic       LINK_RX_ACTIVE,
   output var  logic [7:0] TX_BUFFER_BYTE,
   output var  logic       TX_BUFFER_LOAD,
   output var  logic       CRC_APPEND,
   output var  logic       LINK_HALT,
   output var  logic       LOW_POWER,
   output var  logic       CAL_ACTIVE,
   output var  logic       US_TICK,
   // dma side
   input  wire logic       DMA_TX_WRITE,
   input  wire logic [7:0] DMA_TX_DATA,
   input  wire logic       DMA_RX_READ,
   output var  logic       TX_DMA_REQ,
   output var  logic       RX_DMA_REQ,
   output var  logic       RX_IRQ,
   // pins: transmit, receive, loopback
   input  wire logic       TX_PIN_I,
   output var  logic       TX_PIN_O,
   output var  logic       TX_PIN_OE,
   input  wire logic       RX_PIN_I,
   output var  logic       RX_PIN_O,
   output var  logic       RX_PIN_OE,
   input  wire logic       LP_PIN_I,
   output var  logic       LP_PIN_O,
   output var  logic       LP_PIN_OE
);

   // ***********************************************************
   // state
   // ***********************************************************
   typedef struct packed {
      logic [7:0]                 ctrl;
      logic [4:0]                 clk_mhz;
      logic [7:0]                 tx_bytes_remaining;
      logic [7:0]                 pfunc;
      logic [2:0]                 pout;
      logic [7:0]                 rx_buffer_byte;
      logic                       rx_buffer_full_flag;
      logic                       irq_en;
      logic                       crc_off;
      logic [4:0]                 us_pre;
      logic [vbc_pkg::CAL_W-1:0]  cal_cnt;
      logic [7:0]                 rdata;
      logic [7:0]                 tx_byte;
      logic                       tx_load;
      logic                       crc_append;
      logic                       tx_dma_req;
      logic                       rx_dma_req;
      logic                       irq;
      logic                       halt;
      logic                       low_power;
      logic                       us_tick;
      logic                       rx_active;
      logic [2:0]                 pin_o;
      logic [2:0]                 pin_oe;
   } vbc_state_s;

   vbc_state_s st_r;
   vbc_state_s st_nxt;
   logic [1:0] rst_sync_r;
   logic       rst_n;

   // ***********************************************************
   // functions
   // ***********************************************************

   // effective clock in MHz, out-of-table values time as 25 MHz
   function automatic logic [4:0] eff_mhz(input logic [4:0] code);
      return (code < vbc_pkg::MHZ_MIN || code > vbc_pkg::MHZ_MAX) ? vbc_pkg::MHZ_DFLT
                                                                   : code;
   endfunction

   // register select, one decode shared by reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // ***********************************************************
   // reset release
   // ***********************************************************

   // two-stage release of the asynchronous reset
   always_ff @(posedge CLOCK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_sync_r <= 2'b00;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // ***********************************************************
   // next state
   // ***********************************************************
   always_comb
   begin
      logic       wr_tx;
      logic [7:0] wr_tx_byte;
      logic [7:0] pin_in;
      logic [2:0] fun;
      logic [2:0] dir;
      logic [7:0] rd;

      st_nxt     = st_r;
      wr_tx      = 1'b0;
      wr_tx_byte = vbc_pkg::RST_BYTE;
      pin_in     = {5'h00, TX_PIN_I, RX_PIN_I, LP_PIN_I};
      fun        = st_r.pfunc[vbc_pkg::BIT_FUN_LO +: vbc_pkg::NUM_PINS];
      dir        = st_r.pfunc[vbc_pkg::BIT_DIR_LO +: vbc_pkg::NUM_PINS];
      rd         = vbc_pkg::RST_BYTE;

      // register writes
      if (WR)
      begin
         if (hit(ADDR, vbc_pkg::OFF_CTRL))
         begin
            st_nxt.ctrl = WDATA & vbc_pkg::CTRL_WMASK;
         end
         if (hit(ADDR, vbc_pkg::OFF_CLKSET))
         begin
            st_nxt.clk_mhz = WDATA[4:0];
         end
         if (hit(ADDR, vbc_pkg::OFF_TBC))
         begin
            st_nxt.tx_bytes_remaining = WDATA;
         end
         if (hit(ADDR, vbc_pkg::OFF_PFUNC))
         begin
            st_nxt.pfunc = WDATA;
         end
         if (hit(ADDR, vbc_pkg::OFF_POUT))
         begin
            st_nxt.pout = WDATA[2:0];
         end
         if (hit(ADDR, vbc_pkg::OFF_MIRROR) || hit(ADDR, vbc_pkg::OFF_RXBUF))
         begin
            st_nxt.rx_buffer_byte = WDATA;
         end
         if (hit(ADDR, vbc_pkg::OFF_AUX))
         begin
            st_nxt.irq_en  = WDATA[vbc_pkg::BIT_IRQ_EN];
            st_nxt.crc_off = WDATA[vbc_pkg::BIT_NO_CRC];
         end
         if (hit(ADDR, vbc_pkg::OFF_TXBUF))
         begin
            wr_tx      = 1'b1;
            wr_tx_byte = WDATA;
         end
      end

      // dma write to the transmit buffer when the CPU is not writing it
      if (DMA_TX_WRITE && !wr_tx)
      begin
         wr_tx      = 1'b1;
         wr_tx_byte = DMA_TX_DATA;
      end

      // transmit buffer load, byte count and crc append
      st_nxt.tx_load    = wr_tx;
      st_nxt.crc_append = 1'b0;
      if (wr_tx)
      begin
         st_nxt.tx_byte = wr_tx_byte;
         if (st_r.tx_bytes_remaining == vbc_pkg::RST_BYTE)
         begin
            st_nxt.crc_append = !st_r.crc_off;
         end
         else
         begin
            st_nxt.tx_bytes_remaining = st_r.tx_bytes_remaining - 8'h01;
         end
      end

      // buffer full flag: clear by CPU read or DMA read, set wins
      if (RD && hit(ADDR, vbc_pkg::OFF_RXBUF))
      begin
         st_nxt.rx_buffer_full_flag = 1'b0;
      end
      if (DMA_RX_READ)
      begin
         st_nxt.rx_buffer_full_flag = 1'b0;
      end
      if (RX_BYTE_VALID)
      begin
         st_nxt.rx_buffer_byte      = RX_BYTE;
         st_nxt.rx_buffer_full_flag = 1'b1;
      end
      else if (TX_BYTE_SENT)
      begin
         st_nxt.rx_buffer_byte      = TX_SENT_BYTE;
         st_nxt.rx_buffer_full_flag = 1'b1;
      end

      // completion code event wins over a software write of the enable
      if (CC_FLAG_SET)
      begin
         st_nxt.ctrl[vbc_pkg::BIT_RXDMA] = 1'b0;
      end

      // microsecond time base, stopped in low power
      st_nxt.us_tick = 1'b0;
      if (st_r.ctrl[vbc_pkg::BIT_LOWP])
      begin
         st_nxt.us_pre = 5'h00;
      end
      else if (st_r.us_pre >= eff_mhz(st_r.clk_mhz) - 5'h01)
      begin
         st_nxt.us_pre  = 5'h00;
         st_nxt.us_tick = 1'b1;
      end
      else
      begin
         st_nxt.us_pre = st_r.us_pre + 5'h01;
      end

      // calibration runs a fixed time, then the enable clears itself
      if (!st_r.ctrl[vbc_pkg::BIT_CAL])
      begin
         st_nxt.cal_cnt = '0;
      end
      else if (st_r.us_tick)
      begin
         if (st_r.cal_cnt == vbc_pkg::CAL_CYCLES_US - 1'b1)
         begin
            st_nxt.cal_cnt                = '0;
            st_nxt.ctrl[vbc_pkg::BIT_CAL] = 1'b0;
         end
         else
         begin
            st_nxt.cal_cnt = st_r.cal_cnt + 1'b1;
         end
      end

      // mode outputs
      st_nxt.halt      = st_r.ctrl[vbc_pkg::BIT_SUSP] & DEBUG_MODE;
      st_nxt.low_power = st_r.ctrl[vbc_pkg::BIT_LOWP];

      // dma requests and receive interrupt
      st_nxt.tx_dma_req = st_r.ctrl[vbc_pkg::BIT_TXDMA] & TX_BUF_EMPTY & !wr_tx;
      st_nxt.rx_dma_req = st_r.ctrl[vbc_pkg::BIT_RXDMA] & st_r.rx_buffer_full_flag;
      st_nxt.irq        = st_r.rx_buffer_full_flag & st_r.irq_en;

      // receive pin as seen by the link
      st_nxt.rx_active = st_r.pfunc[vbc_pkg::BIT_RX_POL] ? RX_PIN_I : !RX_PIN_I;

      // pin drivers: link function or plain gpio
      for (int p = 0; p < vbc_pkg::NUM_PINS; p++)
      begin
         st_nxt.pin_o[p]  = st_r.pout[p];
         st_nxt.pin_oe[p] = dir[p];
      end
      if (fun[vbc_pkg::PIN_TX])
      begin
         st_nxt.pin_o[vbc_pkg::PIN_TX]  = st_r.pfunc[vbc_pkg::BIT_TX_POL] ?
                                          LINK_TX_ACTIVE : !LINK_TX_ACTIVE;
         st_nxt.pin_oe[vbc_pkg::PIN_TX] = 1'b1;
      end
      if (fun[vbc_pkg::PIN_RX])
      begin
         st_nxt.pin_o[vbc_pkg::PIN_RX]  = 1'b0;
         st_nxt.pin_oe[vbc_pkg::PIN_RX] = 1'b0;
      end
      if (fun[vbc_pkg::PIN_LP])
      begin
         st_nxt.pin_o[vbc_pkg::PIN_LP]  = !st_r.ctrl[vbc_pkg::BIT_LOOP];
         st_nxt.pin_oe[vbc_pkg::PIN_LP] = 1'b1;
      end

      // read data, valid in the cycle after the strobe only
      if (RD)
      begin
         if (hit(ADDR, vbc_pkg::OFF_CTRL))
         begin
            rd = st_r.ctrl;
         end
         if (hit(ADDR, vbc_pkg::OFF_CLKSET))
         begin
            rd = {3'h0, st_r.clk_mhz};
         end
         if (hit(ADDR, vbc_pkg::OFF_TBC))
         begin
            rd = st_r.tx_bytes_remaining;
         end
         if (hit(ADDR, vbc_pkg::OFF_PFUNC))
         begin
            rd = st_r.pfunc;
         end
         if (hit(ADDR, vbc_pkg::OFF_POUT))
         begin
            rd = {5'h00, st_r.pout};
         end
         if (hit(ADDR, vbc_pkg::OFF_PLEVEL))
         begin
            rd = pin_in;
         end
         if (hit(ADDR, vbc_pkg::OFF_MIRROR) || hit(ADDR, vbc_pkg::OFF_RXBUF))
         begin
            rd = st_r.rx_buffer_byte;
         end
         if (hit(ADDR, vbc_pkg::OFF_AUX))
         begin
            rd[vbc_pkg::BIT_IRQ_EN] = st_r.irq_en;
            rd[vbc_pkg::BIT_NO_CRC] = st_r.crc_off;
            rd[vbc_pkg::BIT_RBF]    = st_r.rx_buffer_full_flag;
         end
      end
      st_nxt.rdata = rd;
   end

   // ***********************************************************
   // state register
   // ***********************************************************

   // all state in one register, reset to a quiet bank
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ***********************************************************
   // outputs, straight from the state register
   // ***********************************************************
   assign RDATA          = st_r.rdata;
   assign LINK_RX_ACTIVE = st_r.rx_active;
   assign TX_BUFFER_BYTE = st_r.tx_byte;
   assign TX_BUFFER_LOAD = st_r.tx_load;
   assign CRC_APPEND     = st_r.crc_append;
   assign LINK_HALT      = st_r.halt;
   assign LOW_POWER      = st_r.low_power;
   assign CAL_ACTIVE     = st_r.ctrl[vbc_pkg::BIT_CAL];
   assign US_TICK        = st_r.us_tick;
   assign TX_DMA_REQ     = st_r.tx_dma_req;
   assign RX_DMA_REQ     = st_r.rx_dma_req;
   assign RX_IRQ         = st_r.irq;
   assign TX_PIN_O       = st_r.pin_o[vbc_pkg::PIN_TX];
   assign TX_PIN_OE      = st_r.pin_oe[vbc_pkg::PIN_TX];
   assign RX_PIN_O       = st_r.pin_o[vbc_pkg::PIN_RX];
   assign RX_PIN_OE      = st_r.pin_oe[vbc_pkg::PIN_RX];
   assign LP_PIN_O       = st_r.pin_o[vbc_pkg::PIN_LP];
   assign LP_PIN_OE      = st_r.pin_oe[vbc_pkg::PIN_LP];

endmodule
`default_nettype wire

// ---- vbc_regs_sva.sv ----
// checker: port-level assertions for the pin and control register bank
`default_nettype none
module vbc_regs_sva
(
   input wire logic       CLOCK,
   input wire logic       RSTN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       RX_BYTE_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic       TX_BYTE_SENT,
   input wire logic       CC_FLAG_SET,
   input wire logic       TX_BUF_EMPTY,
   input wire logic       DEBUG_MODE,
   input wire logic [7:0] TX_BUFFER_BYTE,
   input wire logic       TX_BUFFER_LOAD,
   input wire logic       CRC_APPEND,
   input wire logic       LINK_HALT,
   input wire logic       LOW_POWER,
   input wire logic       CAL_ACTIVE,
   input wire logic       DMA_TX_WRITE,
   input wire logic [7:0] DMA_TX_DATA,
   input wire logic       TX_DMA_REQ,
   input wire logic       RX_DMA_REQ,
   input wire logic       RX_IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // clocking, decodes and sequences
   // ************************************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // decoded strobes
   wire logic cpu_tx = WR && ADDR == vbc_pkg::OFF_TXBUF;
   wire logic ctl_wr = WR && ADDR == vbc_pkg::OFF_CTRL;
   // mirror read that follows a received byte
   sequence s_mirror_rd;
      RD && ADDR == vbc_pkg::OFF_MIRROR;
   endsequence
   // buffer read with no new byte racing it
   sequence s_rxbuf_rd;
      RD && ADDR == vbc_pkg::OFF_RXBUF && !RX_BYTE_VALID && !TX_BYTE_SENT;
   endsequence
   property p_mirror;
      logic [7:0] b;
      (RX_BYTE_VALID, b = RX_BYTE) ##1 s_mirror_rd |=> RDATA == b;
   endproperty
   // ************************************************************
   // assertions
   // ************************************************************
   a_cal_start: assert property (ctl_wr && WDATA[6] |-> ##[1:2] CAL_ACTIVE)
      else $error("calibration did not start");
   a_lowp_enter: assert property (ctl_wr && WDATA[0] |-> ##[1:2] LOW_POWER)
      else $error("low power not entered");
   a_txdma_empty: assert property (TX_DMA_REQ |-> $past(TX_BUF_EMPTY))
      else $error("tx dma request without empty buffer");
   a_rxdma_cc: assert property (CC_FLAG_SET |-> ##2 !RX_DMA_REQ)
      else $error("rx dma request after completion code");
   a_halt_off: assert property (!DEBUG_MODE |=> !LINK_HALT)
      else $error("halt outside debug");
   a_cpu_load: assert property (cpu_tx |=> TX_BUFFER_LOAD && TX_BUFFER_BYTE == $past(WDATA))
      else $error("cpu tx write not loaded");
   a_dma_load: assert property (DMA_TX_WRITE && !cpu_tx |=>
      TX_BUFFER_LOAD && TX_BUFFER_BYTE == $past(DMA_TX_DATA))
      else $error("dma tx write not loaded");
   a_load_cause: assert property (TX_BUFFER_LOAD |-> $past(cpu_tx) || $past(DMA_TX_WRITE))
      else $error("tx load without write");
   a_crc_load: assert property (CRC_APPEND |-> TX_BUFFER_LOAD)
      else $error("crc append without load");
   a_mirror_byte: assert property (p_mirror)
      else $error("mirror byte differs");
   a_rx_rd_clear: assert property (s_rxbuf_rd |-> ##2 !RX_IRQ && !RX_DMA_REQ)
      else $error("buffer read left flag set");
endmodule
bind vbc_regs vbc_regs_sva u_sva (.CLOCK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA,
   .RX_BYTE_VALID, .RX_BYTE, .TX_BYTE_SENT, .CC_FLAG_SET, .TX_BUF_EMPTY, .DEBUG_MODE,
   .TX_BUFFER_BYTE, .TX_BUFFER_LOAD, .CRC_APPEND, .LINK_HALT, .LOW_POWER, .CAL_ACTIVE,
   .DMA_TX_WRITE, .DMA_TX_DATA, .TX_DMA_REQ, .RX_DMA_REQ, .RX_IRQ);
`default_nettype wire

// ---- vbc_xcvr.sv ----
// transceiver model: loopback tie and wired-or bus feeding the receive pin
`default_nettype none
module vbc_xcvr
(
   input  wire logic tx_lvl,
   input  wire logic lp_n_lvl,
   input  wire logic bus_other,
   output var  logic rx_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   // loopback low ties transmit to receive, else the wired-or bus state
   always_comb rx_drv = lp_n_lvl ? (tx_lvl | bus_other) : tx_lvl;
endmodule
`default_nettype wire
